/* rtl/ppsm_pkg.sv */
//****************************************************************
// What this block does
// RL1 - port select pin follows config bit 15
// RL2 - serial tx enable low while nibble port
// RL3 - serial inputs ignored while nibble port selected
// RL4 - serial port sends one NRZ bit stream
// RL5 - serial clocks from transceiver pace serial transfer
// RL6 - fast tx enable frames send, low otherwise
// RL7 - nibble inputs ignored while serial port selected
// RL8 - fast carrier drives deferral, fast collision drives backoff
// RL9 - receive nibbles taken only while valid high
// RL10 - transmit nibbles follow the fast tx clock
// RL11 - loopback pin follows loop bit always
// RL12 - link pin shown in status bit 14
// RL13 - step mode pin is inverse of bit 10
// RL14 - attach unit pin follows config bit 8
// RL15 - write indicator pulses per stored receive byte
// RL16 - receive nibbles ignored while serial selected
// RL17 - port switch only between frames
//****************************************************************
package ppsm_pkg;
  // register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] TCR_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] TXDATA_OFS = 8'h0c;
  localparam logic [7:0] RXDATA_OFS = 8'h10;
  // config fields
  localparam int CFG_PORT_BIT = 15;
  localparam int CFG_STEP_BIT = 10;
  localparam int CFG_AUI_BIT = 8;
  localparam logic [31:0] CFG_MASK = 32'h0000_8500;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // transmit control fields
  localparam int TCR_GO_BIT = 0;
  localparam int TCR_LOOP_BIT = 1;
  localparam logic [31:0] TCR_MASK = 32'h0000_0003;
  localparam logic [31:0] TCR_RST = 32'h0000_0000;
  // status fields
  localparam int STAT_TXBUSY_BIT = 0;
  localparam int STAT_RXBUSY_BIT = 1;
  localparam int STAT_PORT_BIT = 2;
  localparam int STAT_COLL_BIT = 3;
  localparam int STAT_FULL_BIT = 4;
  localparam int STAT_LINK_BIT = 14;
  // data path shape
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  localparam int NIB_W = 4;
  localparam logic [3:0] SER_UNITS = 4'h8;
  localparam logic [3:0] MII_UNITS = 4'h2;
  // transmit sequencer states
  typedef enum logic {TX_IDLE, TX_SEND} ppsm_tx_state_t;
endpackage

/* rtl/ppsm_top.sv */
`timescale 1ns/1ps
`default_nettype none

//****************************************************************
// two-stage synchroniser
//****************************************************************
module ppsm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // first stage, read only by q

  // two flops per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//****************************************************************
// transmit byte fifo
//****************************************************************
module ppsm_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // storage words
  logic [AW-1:0] wp_r; // write pointer
  logic [AW-1:0] rp_r; // read pointer
  logic [AW:0] cnt_r; // fill level
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // pointers and level; depth is a power of two so pointers wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//****************************************************************
// port logic top
//****************************************************************
module ppsm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_tx_clock,
  input wire logic serial_rx_clock,
  input wire logic serial_carrier,
  input wire logic serial_collision,
  input wire logic serial_rx_data,
  output logic serial_tx_enable,
  output logic serial_tx_data,
  input wire logic fast_tx_clock,
  input wire logic fast_rx_clock,
  input wire logic fast_carrier,
  input wire logic fast_rx_valid,
  input wire logic fast_collision,
  input wire logic [3:0] fast_rx_nibble,
  output logic fast_tx_enable,
  output logic [3:0] fast_tx_nibble,
  input wire logic link_status_in_n,
  output logic loopback_out,
  output logic step_mode_out_n,
  output logic attach_unit_select_out,
  output logic phy_port_select,
  output logic receive_write_indicator
);
  //**************************************************************
  // pin synchronisers and edge finders
  //**************************************************************
  logic [14:0] pins_s; // synchronised pins
  logic s_txc, s_rxc, s_crs, s_col, s_rxd; // serial side
  logic f_txc, f_rxc, f_crs, f_dv, f_col; // nibble side
  logic [3:0] f_nib; // receive nibble
  logic link_s; // link pin level
  logic [3:0] clk_d_r; // delayed clock samples
  logic s_tx_rise, s_rx_rise, f_tx_rise, f_rx_rise;

  ppsm_sync #(.W(15)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({link_status_in_n, fast_rx_nibble, fast_collision,
        fast_rx_valid, fast_carrier, ~fast_rx_clock, ~fast_tx_clock,
        serial_rx_data, serial_collision, serial_carrier,
        ~serial_rx_clock, ~serial_tx_clock}),
    .q(pins_s)
  );
  assign {link_s, f_nib, f_col, f_dv, f_crs, f_rxc, f_txc,
          s_rxd, s_col, s_crs, s_rxc, s_txc} = pins_s;

  // previous clock samples for rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d_r <= '0;
    end else begin
      clk_d_r <= {f_rxc, f_txc, s_rxc, s_txc};
    end
  end
  // clocks enter inverted: their pulled-up idle level then equals the
  // synchroniser reset value, so no false edge follows reset
  assign s_tx_rise = ~s_txc & clk_d_r[0];
  assign s_rx_rise = ~s_rxc & clk_d_r[1];
  assign f_tx_rise = ~f_txc & clk_d_r[2];
  assign f_rx_rise = ~f_rxc & clk_d_r[3];

  //**************************************************************
  // apb slave and registers
  //**************************************************************
  logic [31:0] cfg_r; // configuration
  logic [31:0] tcr_r; // transmit control
  logic coll_r; // sticky collision seen
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_mux;
  logic hit, acc, wr, txd_wr_req;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out;
  logic coll_evt;
  logic active_r; // port in use by the engine
  ppsm_pkg::ppsm_tx_state_t tx_state_r;
  logic rx_busy;
  logic [7:0] rx_last_r; // last stored byte
  logic [15:0] rx_count_r; // stored byte count

  assign hit = (paddr == ppsm_pkg::CFG_OFS) |
               (paddr == ppsm_pkg::TCR_OFS) |
               (paddr == ppsm_pkg::STAT_OFS) |
               (paddr == ppsm_pkg::TXDATA_OFS) |
               (paddr == ppsm_pkg::RXDATA_OFS);
  assign acc = psel & penable & pready_r;
  assign wr = acc & pwrite;
  assign txd_wr_req = pwrite & (paddr == ppsm_pkg::TXDATA_OFS);

  // read data selection
  always_comb begin
    rd_mux = '0;
    case (paddr)
      ppsm_pkg::CFG_OFS: rd_mux = cfg_r;
      ppsm_pkg::TCR_OFS: rd_mux = tcr_r;
      ppsm_pkg::STAT_OFS: begin
        rd_mux[ppsm_pkg::STAT_LINK_BIT] = link_s; // see RL12
        rd_mux[ppsm_pkg::STAT_TXBUSY_BIT] =
          (tx_state_r == ppsm_pkg::TX_SEND);
        rd_mux[ppsm_pkg::STAT_RXBUSY_BIT] = rx_busy;
        rd_mux[ppsm_pkg::STAT_PORT_BIT] = active_r;
        rd_mux[ppsm_pkg::STAT_COLL_BIT] = coll_r;
        rd_mux[ppsm_pkg::STAT_FULL_BIT] = ~fifo_in_ready;
      end
      ppsm_pkg::RXDATA_OFS: rd_mux = {rx_count_r, 8'h00, rx_last_r};
      default: rd_mux = '0;
    endcase
  end

  // answer one cycle after setup; a full fifo stalls tx data writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= psel & ~pready_r & (~txd_wr_req | fifo_in_ready);
      pslverr_r <= psel & ~pready_r & ~hit;
      if (psel & ~pready_r) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // software-written control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= ppsm_pkg::CFG_RST;
      tcr_r <= ppsm_pkg::TCR_RST;
    end else begin
      if (wr && paddr == ppsm_pkg::CFG_OFS) begin
        cfg_r <= pwdata & ppsm_pkg::CFG_MASK;
      end
      if (wr && paddr == ppsm_pkg::TCR_OFS) begin
        tcr_r <= pwdata & ppsm_pkg::TCR_MASK;
      end
    end
  end

  // sticky collision flag, set beats write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_r <= 1'b0;
    end else if (coll_evt) begin
      coll_r <= 1'b1;
    end else if (wr && paddr == ppsm_pkg::STAT_OFS &&
                 pwdata[ppsm_pkg::STAT_COLL_BIT]) begin
      coll_r <= 1'b0;
    end
  end

  //**************************************************************
  // port steering
  //**************************************************************
  logic tx_edge, rx_edge, carrier, collision, rx_valid;

  // engine follows only the active port's pins
  assign tx_edge = active_r ? f_tx_rise : s_tx_rise; // see RL5
  assign rx_edge = active_r ? f_rx_rise : s_rx_rise; // see RL3
  assign carrier = active_r ? f_crs : s_crs; // see RL8
  assign collision = active_r ? f_col : s_col; // see RL7
  assign rx_valid = active_r ? f_dv : s_crs; // see RL9
  assign rx_busy = rx_valid;

  // switch the engine only with no frame either way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b0;
    end else if (tx_state_r == ppsm_pkg::TX_IDLE && !rx_busy) begin
      active_r <= cfg_r[ppsm_pkg::CFG_PORT_BIT]; // see RL17
    end
  end

  //**************************************************************
  // transmit path
  //**************************************************************
  logic [7:0] tx_sh_r; // outgoing byte remainder
  logic [3:0] tx_units_r; // units left in byte
  logic [3:0] tx_unit_r; // unit on the wire
  logic tx_drive_r; // frame on the wire
  logic need_load;
  logic [7:0] tx_src;

  ppsm_fifo #(.W(ppsm_pkg::FIFO_W), .D(ppsm_pkg::FIFO_D)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(wr && paddr == ppsm_pkg::TXDATA_OFS),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  assign need_load = (tx_units_r == '0);
  assign tx_src = need_load ? fifo_out : tx_sh_r;
  assign fifo_pop = tx_edge & (tx_state_r == ppsm_pkg::TX_SEND) &
                    need_load & ~collision;
  assign coll_evt = tx_edge & (tx_state_r == ppsm_pkg::TX_SEND) &
                    collision;

  // sequencer, one unit per edge of the active tx clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= ppsm_pkg::TX_IDLE;
      tx_sh_r <= '0;
      tx_units_r <= '0;
      tx_unit_r <= '0;
      tx_drive_r <= 1'b0;
    end else if (tx_edge) begin
      case (tx_state_r)
        ppsm_pkg::TX_IDLE: begin
          // defer while the medium carries traffic
          if (tcr_r[ppsm_pkg::TCR_GO_BIT] && fifo_out_valid &&
              !carrier) begin // see RL8
            tx_state_r <= ppsm_pkg::TX_SEND;
            tx_units_r <= '0;
          end
        end
        ppsm_pkg::TX_SEND: begin
          if (collision || (need_load && !fifo_out_valid)) begin
            // collision backs off, empty fifo ends the frame
            tx_state_r <= ppsm_pkg::TX_IDLE;
            tx_drive_r <= 1'b0;
            tx_unit_r <= '0;
          end else if (active_r) begin
            // nibble per edge, low nibble first
            tx_unit_r <= tx_src[3:0]; // see RL10
            tx_sh_r <= tx_src >> ppsm_pkg::NIB_W;
            tx_units_r <= (need_load ? ppsm_pkg::MII_UNITS
                                     : tx_units_r) - 4'h1;
            tx_drive_r <= 1'b1;
          end else begin
            // single nrz bit per edge, lsb first
            tx_unit_r <= {3'h0, tx_src[0]}; // see RL4
            tx_sh_r <= tx_src >> 1;
            tx_units_r <= (need_load ? ppsm_pkg::SER_UNITS
                                     : tx_units_r) - 4'h1;
            tx_drive_r <= 1'b1;
          end
        end
        default: tx_state_r <= ppsm_pkg::TX_IDLE;
      endcase
    end
  end

  //**************************************************************
  // receive path
  //**************************************************************
  logic [7:0] rx_acc_r; // byte under assembly
  logic [3:0] rx_units_r; // units gathered
  logic rx_wr_r; // byte stored this cycle
  logic [3:0] rx_per;

  assign rx_per = active_r ? ppsm_pkg::MII_UNITS : ppsm_pkg::SER_UNITS;

  // gather units on edges of the active rx clock while valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_acc_r <= '0;
      rx_units_r <= '0;
      rx_last_r <= '0;
      rx_count_r <= '0;
      rx_wr_r <= 1'b0;
    end else begin
      rx_wr_r <= 1'b0;
      if (!rx_valid) begin
        // out of frame, drop any partial byte
        rx_units_r <= '0;
      end else if (rx_edge) begin
        if (rx_units_r == rx_per - 4'h1) begin
          // byte complete, write it to buffer
          rx_last_r <= active_r ? {f_nib, rx_acc_r[7:4]}
                                : {s_rxd, rx_acc_r[7:1]};
          rx_count_r <= rx_count_r + 16'h0001;
          rx_wr_r <= 1'b1; // see RL15
          rx_units_r <= '0;
        end else begin
          rx_units_r <= rx_units_r + 4'h1;
        end
        if (active_r) begin
          rx_acc_r <= {f_nib, rx_acc_r[7:4]}; // see RL16
        end else begin
          rx_acc_r <= {s_rxd, rx_acc_r[7:1]};
        end
      end
    end
  end

  //**************************************************************
  // output flops
  //**************************************************************
  logic out_ser_en_r, out_ser_d_r, out_fast_en_r;
  logic [3:0] out_fast_nib_r;
  logic out_loop_r, out_step_n_r, out_aui_r, out_port_r;

  // enable pins gated by the live config bit, not only the engine port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ser_en_r <= 1'b0;
      out_ser_d_r <= 1'b0;
      out_fast_en_r <= 1'b0;
      out_fast_nib_r <= '0;
    end else begin
      out_ser_en_r <= tx_drive_r & ~active_r &
                      ~cfg_r[ppsm_pkg::CFG_PORT_BIT]; // see RL2
      out_ser_d_r <= tx_unit_r[0] & ~active_r;
      out_fast_en_r <= tx_drive_r & active_r &
                       cfg_r[ppsm_pkg::CFG_PORT_BIT]; // see RL6
      out_fast_nib_r <= active_r ? tx_unit_r : 4'h0;
    end
  end

  // static configuration pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_loop_r <= 1'b0;
      out_step_n_r <= 1'b1;
      out_aui_r <= 1'b0;
      out_port_r <= 1'b0;
    end else begin
      out_loop_r <= tcr_r[ppsm_pkg::TCR_LOOP_BIT]; // see RL11
      out_step_n_r <= ~cfg_r[ppsm_pkg::CFG_STEP_BIT]; // see RL13
      out_aui_r <= cfg_r[ppsm_pkg::CFG_AUI_BIT]; // see RL14
      out_port_r <= cfg_r[ppsm_pkg::CFG_PORT_BIT]; // see RL1
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign serial_tx_enable = out_ser_en_r;
  assign serial_tx_data = out_ser_d_r;
  assign fast_tx_enable = out_fast_en_r;
  assign fast_tx_nibble = out_fast_nib_r;
  assign loopback_out = out_loop_r;
  assign step_mode_out_n = out_step_n_r;
  assign attach_unit_select_out = out_aui_r;
  assign phy_port_select = out_port_r;
  assign receive_write_indicator = rx_wr_r;

  //**************************************************************
  // assertions
  //**************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_cfg, wr_tcr, rd_stat;
  assign wr_cfg = wr && paddr == ppsm_pkg::CFG_OFS;
  assign wr_tcr = wr && paddr == ppsm_pkg::TCR_OFS;
  assign rd_stat = psel & ~pready_r & ~pwrite &
                   (paddr == ppsm_pkg::STAT_OFS);

  a_port_pin: assert property ( // see RL1
    wr_cfg |-> ##2 phy_port_select == $past(pwdata[15], 2))
    else $error("port select pin missed config write");
  a_serial_quiet: assert property ( // see RL2
    cfg_r[ppsm_pkg::CFG_PORT_BIT] |=> !serial_tx_enable)
    else $error("serial tx enable high on nibble port");
  a_serial_ignored: assert property ( // see RL3
    (active_r && !f_rx_rise) |=> $stable(rx_count_r))
    else $error("serial rx clock counted on nibble port");
  a_serial_pace: assert property ( // see RL5
    $changed(serial_tx_data) |-> $past(s_tx_rise, 2))
    else $error("serial bit changed off its clock");
  a_fast_quiet: assert property ( // see RL6
    !cfg_r[ppsm_pkg::CFG_PORT_BIT] |=> !fast_tx_enable)
    else $error("fast tx enable high on serial port");
  a_fast_ignored: assert property ( // see RL7
    (!active_r && !s_rx_rise) |=> $stable(rx_count_r))
    else $error("nibble rx clock counted on serial port");
  a_defer_carrier: assert property ( // see RL8
    (tx_state_r == ppsm_pkg::TX_IDLE && carrier) |=>
      tx_state_r == ppsm_pkg::TX_IDLE)
    else $error("transmit started under carrier");
  a_valid_frames: assert property ( // see RL9
    (active_r && !f_dv) |=> $stable(rx_count_r))
    else $error("nibble taken without valid");
  a_nibble_pace: assert property ( // see RL10
    $changed(fast_tx_nibble) |-> $past(f_tx_rise, 2))
    else $error("tx nibble changed off its clock");
  a_loop_pin: assert property ( // see RL11
    wr_tcr |-> ##2 loopback_out == $past(pwdata[1], 2))
    else $error("loopback pin missed loop bit");
  a_link_read: assert property ( // see RL12
    rd_stat |=> prdata[14] == $past(link_s))
    else $error("status bit 14 not the link pin");
  a_step_pin: assert property ( // see RL13
    wr_cfg |-> ##2 step_mode_out_n == !$past(pwdata[10], 2))
    else $error("step mode pin not inverse of bit");
  a_aui_pin: assert property ( // see RL14
    wr_cfg |-> ##2 attach_unit_select_out == $past(pwdata[8], 2))
    else $error("attach unit pin missed config bit");
  a_write_pulse: assert property ( // see RL15
    receive_write_indicator == (rx_count_r != $past(rx_count_r)))
    else $error("write indicator not tied to stored byte");
  a_switch_idle: assert property ( // see RL17
    $changed(active_r) |-> $past(tx_state_r == ppsm_pkg::TX_IDLE &&
                                 !rx_busy))
    else $error("port switched inside a frame");

  c_serial_send: cover property (serial_tx_enable ##1 !serial_tx_enable);
  c_fast_send: cover property (fast_tx_enable ##1 !fast_tx_enable);
  c_rx_byte: cover property (active_r && receive_write_indicator);
  c_switch: cover property ($rose(active_r));
endmodule

`default_nettype wire

/* tb/ppsm_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
//****
// far side transceiver model
//****
module ppsm_phy_model (
  input wire logic tx_on,
  input wire logic serial_tx_enable,
  input wire logic serial_tx_data,
  input wire logic fast_tx_enable,
  input wire logic [3:0] fast_tx_nibble,
  output logic serial_tx_clock,
  output logic fast_tx_clock,
  output logic serial_rx_clock,
  output logic fast_rx_clock,
  output logic serial_carrier,
  output logic serial_rx_data,
  output logic fast_carrier,
  output logic fast_rx_valid,
  output logic [3:0] fast_rx_nibble,
  output logic [7:0] cap_byte,
  output logic cap_stb
);
  logic [7:0] sr; // capture shifter
  int n; // bits gathered
  // clocks idle high (pull-ups); rx clocks run only inside frames, tx clocks whenever tx_on is high
  initial begin
    {serial_rx_clock, fast_rx_clock, serial_rx_data} = 3'h7;
    {serial_carrier, fast_carrier, fast_rx_valid, cap_stb} = 4'h0;
    fast_rx_nibble = 4'h0;
    serial_tx_clock = 1'b1;
    forever begin
      #80 serial_tx_clock = tx_on ? ~serial_tx_clock : 1'b1;
      fast_tx_clock = serial_tx_clock;
    end
  end
  // gather units, low end first, one byte at a time
  always @(posedge serial_tx_clock) begin
    if (serial_tx_enable || fast_tx_enable) begin
      if (serial_tx_enable) sr = {serial_tx_data, sr[7:1]};
      else sr = {fast_tx_nibble, sr[7:4]};
      n += serial_tx_enable ? 1 : 4;
      if (n == 8) begin
        cap_byte = sr;
        cap_stb = ~cap_stb;
        n = 0;
      end
    end else n = 0;
  end
  // one received byte on either port, data moved on falling clock
  task automatic send(input logic fast, input logic [7:0] b);
    serial_carrier = !fast;
    {fast_rx_valid, fast_carrier} = {2{fast}};
    for (int i = 0; i < 8; i += fast ? 4 : 1) begin
      {serial_rx_clock, fast_rx_clock} = 2'h0;
      serial_rx_data = b[i];
      fast_rx_nibble = 4'(b >> i);
      #80 {serial_rx_clock, fast_rx_clock} = 2'h3;
      #80;
    end
    #80 {serial_carrier, fast_carrier, fast_rx_valid} = 3'h0;
    serial_rx_data = 1'b1; // pull-up level
    fast_rx_nibble = ~fast_rx_nibble; // released line
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_on;
  logic [7:0] paddr, cap_byte, last;
  logic [31:0] pwdata, prdata, rnd;
  logic serial_tx_clock, serial_rx_clock, serial_carrier, serial_rx_data;
  logic serial_collision, serial_tx_enable, serial_tx_data, cap_stb;
  logic fast_tx_clock, fast_rx_clock, fast_carrier, fast_rx_valid;
  logic fast_collision, fast_tx_enable, link_status_in_n, loopback_out;
  logic [3:0] fast_rx_nibble, fast_tx_nibble;
  logic step_mode_out_n, attach_unit_select_out, phy_port_select;
  logic receive_write_indicator;
  logic [64:0] bus_q[$]; // mask, error, data
  logic [64:0] note;
  logic [7:0] tx_q[$]; // bytes due on the wire
  int err_total, total_checks, cyc, pulses;
  ppsm_top dut (.*);
  ppsm_phy_model phy (.*);
  //****
  // helpers
  //****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // apb transfer, notes expected answer first
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    bus_q.push_back({m, e, d & m});
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
  // send queued bytes, other port's enable must stay low
  task automatic drain(input logic fast);
    tx_on <= 1'b1;
    while (tx_q.size() != 0) begin
      @(posedge pclk);
      cmp(32'(fast ? serial_tx_enable : fast_tx_enable), 32'h0);
    end
    repeat (40) @(posedge pclk);
    tx_on <= 1'b0;
  endtask
  //****
  // watchers and clock
  //****
  always @(posedge pclk) if (psel && penable && pready === 1'b1) begin
    note = bus_q.pop_front();
    cmp(32'(pslverr), 32'(note[32]));
    cmp(prdata & note[64:33], note[31:0]);
  end
  always @(cap_stb) if ($time > 0) cmp(32'(cap_byte), 32'(tx_q.pop_front()));
  always @(posedge pclk) begin
    pulses += (receive_write_indicator === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  //****
  // main sequence
  //****
  initial begin
    {presetn, psel, penable, pwrite, tx_on} = 5'h0;
    {serial_collision, fast_collision, link_status_in_n} = 3'h1;
    {paddr, pwdata, rnd} = {8'h0, 32'h0, 32'ha5cc};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cmp(32'({step_mode_out_n, phy_port_select, loopback_out}), 32'h4);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      link_status_in_n <= rnd[3];
      apb(1'b1, ppsm_pkg::CFG_OFS, rnd, 32'h0, 1'b0);
      apb(1'b1, ppsm_pkg::TCR_OFS, rnd & 32'h2, 32'h0, 1'b0);
      repeat (4) @(posedge pclk);
      cmp(32'(phy_port_select), 32'(rnd[15]));
      cmp(32'(step_mode_out_n), 32'(!rnd[10]));
      cmp(32'(attach_unit_select_out), 32'(rnd[8]));
      cmp(32'(loopback_out), 32'(rnd[1]));
      apb(1'b0, ppsm_pkg::STAT_OFS, 32'(rnd[3]) << 14, 32'h4000, 1'b0);
    end
    apb(1'b0, 8'h20, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, ppsm_pkg::CFG_OFS, 32'h8000, 32'h0, 1'b0);
    for (int i = 0; i < 17; i++) begin
      rnd = lfsr(rnd);
      tx_q.push_back(rnd[7:0]);
      if (i == 16) apb(1'b1, ppsm_pkg::TCR_OFS, 32'h1, 32'h0, 1'b0);
      if (i == 16) tx_on <= 1'b1;
      if (i == 16) apb(1'b0, ppsm_pkg::STAT_OFS, 32'h10, 32'h10, 1'b0);
      apb(1'b1, ppsm_pkg::TXDATA_OFS, rnd, 32'h0, 1'b0);
    end
    serial_collision <= 1'b1; // other port's collision is ignored
    drain(1'b1);
    serial_collision <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      if (i == 3) apb(1'b1, ppsm_pkg::CFG_OFS, 32'h0, 32'h0, 1'b0);
      phy.send(i != 4, rnd[7:0]);
      if (i != 3) last = rnd[7:0];
    end
    repeat (8) @(posedge pclk);
    cmp(32'(pulses), 32'h4);
    apb(1'b0, ppsm_pkg::RXDATA_OFS, {16'h4, 8'h0, last}, 32'hffff00ff, 1'b0);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      tx_q.push_back(rnd[7:0]);
      apb(1'b1, ppsm_pkg::TXDATA_OFS, rnd, 32'h0, 1'b0);
    end
    fast_collision <= 1'b1; // other port's collision is ignored
    drain(1'b0);
    apb(1'b0, ppsm_pkg::STAT_OFS, 32'h0, 32'h8, 1'b0);
    // collision on the live port backs off and sets the sticky flag
    rnd = lfsr(rnd);
    serial_collision <= 1'b1;
    apb(1'b1, ppsm_pkg::TXDATA_OFS, rnd, 32'h0, 1'b0);
    tx_on <= 1'b1;
    repeat (40) @(posedge pclk);
    tx_on <= 1'b0;
    repeat (12) @(posedge pclk);
    apb(1'b0, ppsm_pkg::STAT_OFS, 32'h8, 32'h8, 1'b0);
    serial_collision <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, ppsm_pkg::STAT_OFS, 32'h8, 32'h0, 1'b0);
    apb(1'b0, ppsm_pkg::STAT_OFS, 32'h0, 32'h8, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
